/* File: dv/omcs_osc_model.sv */
/*
  Far-side oscillator: a square wave on the osc_in line, half period in clk cycles.
  Assumes the bench holds half steady while run is high.
*/
`timescale 1ns/1ps
module omcs_osc_model (
  // Clock
  input  wire logic       clk,
  // Bench control
  input  wire logic       run,
  input  wire logic [7:0] half,
  // Line into the device
  output logic            osc
);
  logic [7:0] cnt_r;

  initial osc = 1'b0;
  // Stops low between runs; half of 8 keeps a PLL crystal under 10 MHz
  always @(posedge clk) begin
    if (!run) begin
      osc <= 1'b0;
      cnt_r <= 8'h00;
    end else if (cnt_r + 8'h01 >= half) begin
      osc <= ~osc;
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule : omcs_osc_model

/* File: dv/omcs_props.sv */
/*
  Port checker of omcs_top, bound into it.
  Assumes one clock domain and nrst as the only reset.
*/
`timescale 1ns/1ps
module omcs_props (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // Bus
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         readdata,
  input  wire logic                waitrequest,
  // Pins and core
  input  wire omcs_pkg::omcs_pin_t osc_in_pin_drv,
  input  wire logic                sleep_req,
  input  wire logic                sys_clk_tick,
  input  wire omcs_pkg::omcs_src_t src_status
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ****************************************
  // Bus
  // ****************************************
  property p_wait_first;
    (read || write) && !$past(read || write) |-> waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("no wait cycle on new request");
  property p_wait_one;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("more than one wait cycle");
  property p_rdata_hold;
    $changed(readdata) |-> read && !waitrequest;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("readdata moved without a read");

  // ****************************************
  // Clock sources
  // ****************************************
  property p_pll_space;
    src_status.pll && sys_clk_tick |=> (!sys_clk_tick || !src_status.pll) [*3];
  endproperty
  a_pll_space: assert property (p_pll_space)
    else $error("PLL ticks faster than 40 MHz");
  property p_pll_alone;
    src_status.pll |-> !src_status.fast;
  endproperty
  a_pll_alone: assert property (p_pll_alone)
    else $error("PLL on with fast source");
  property p_fast_slow;
    src_status.fast |-> src_status.slow;
  endproperty
  a_fast_slow: assert property (p_fast_slow)
    else $error("fast source on without slow source");
  property p_tick_ready;
    sys_clk_tick |-> src_status.ready && !sleep_req;
  endproperty
  a_tick_ready: assert property (p_tick_ready)
    else $error("tick while not ready or asleep");
  property p_tick_pulse;
    sys_clk_tick && !src_status.pll && !src_status.fast |=> !sys_clk_tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("tick longer than one cycle");
  property p_in_oe;
    osc_in_pin_drv.oe |-> src_status.slow && !src_status.pll;
  endproperty
  a_in_oe: assert property (p_in_oe)
    else $error("in pin driven outside internal modes");
endmodule : omcs_props

bind omcs_top omcs_props u_omcs_props (.clk(clk), .nrst(nrst), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .osc_in_pin_drv(osc_in_pin_drv),
  .sleep_req(sleep_req), .sys_clk_tick(sys_clk_tick), .src_status(src_status));

/* File: dv/omcs_top_test.sv */
/*
  Self-checking bench of omcs_top: bus tasks, oscillator model, tick counts, pins.
  Assumes omcs_pkg is compiled and omcs_defs.svh is on the include path.
*/
`timescale 1ns/1ps
`include "omcs_defs.svh"
module omcs_top_test;
  localparam int OST = 4;
  logic clk, nrst, read, write, sleep_req, ext6, run, osc_w, sys_clk_tick, waitrequest;
  logic [7:0] address, half;
  logic [31:0] writedata, readdata, exp_q[$];
  omcs_pkg::omcs_pin_t in_drv, out_drv;
  omcs_pkg::omcs_src_t src_status;
  int error_cnt, n_checks, tick_n, tog_n, cyc, t, g, m, h, r;
  logic last_o;
  logic [1:0] pv;
  wire in_w = in_drv.oe ? in_drv.o : osc_w;
  wire out_w = out_drv.oe ? out_drv.o : ext6;

  omcs_top #(.OST_EDGES(OST)) u_omcs_top (.clk(clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .osc_in_pin_i(in_w), .osc_in_pin_drv(in_drv),
    .osc_out_pin_i(out_w), .osc_out_pin_drv(out_drv), .sleep_req(sleep_req),
    .sys_clk_tick(sys_clk_tick), .src_status(src_status));
  omcs_osc_model u_omcs_osc_model (.clk(clk), .run(run), .half(half), .osc(osc_w));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    n_checks++;
    if (v !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, v);
    end
  endtask : chk
  task automatic chk_near(input string nm, input int e, input int v);
    n_checks++;
    if (v < e - 1 || v > e + 1) begin
      error_cnt++;
      $display("BAD %s exp %0d got %0d", nm, e, v);
    end
  endtask : chk_near
  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  // Two periods to settle, then ticks and toggles over exactly k periods
  task automatic pulse(input int k, input int hh, output int tt, output int gg);
    int t0;
    int g0;
    half <= 8'(hh);
    run <= 1'b1;
    repeat (4 * hh) @(posedge clk);
    @(negedge clk);
    t0 = tick_n;
    g0 = tog_n;
    repeat (k * 2 * hh) @(negedge clk);
    tt = tick_n - t0;
    gg = tog_n - g0;
    @(posedge clk);
    run <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // ****************************************
  // Monitor and timeout
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    tick_n += int'(sys_clk_tick === 1'b1);
    tog_n += int'(out_drv.o !== last_o);
    last_o = out_drv.o;
    if (read && waitrequest === 1'b0)
      chk("readdata", exp_q.pop_front(), readdata);
    if (cyc > 90000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {nrst, read, write, sleep_req, ext6, run, last_o} = 7'h00;
    {address, half, writedata} = 48'h0;
    r = $urandom(48);
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`OMCS_ADDR_CFG, 32'h0000_0007);
    rd(`OMCS_ADDR_CTRL, 32'h0000_0000);
    rd(`OMCS_ADDR_STAT, 32'h0000_0003);
    rd(`OMCS_ADDR_FEAT, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    wr(`OMCS_ADDR_STAT, 32'h0000_000f);
    rd(`OMCS_ADDR_STAT, 32'h0000_0003);
    wr(`OMCS_ADDR_TRIS, 32'h0000_0000);
    $display("test reset done");
    for (m = 0; m < 10; m++) begin
      wr(`OMCS_ADDR_CFG, 32'(m));
      rd(`OMCS_ADDR_STAT, 32'({m == 3, 1'b0, m == 6 || m == 7, m > 3}));
      chk("out oe", 32'(!(m inside {5, 7, 9})), 32'(out_drv.oe));
      chk("in oe", 32'h0000_0000, 32'(in_drv.oe));
    end
    wr(`OMCS_ADDR_FEAT, 32'h0000_0001 << ($urandom % 4));
    rd(`OMCS_ADDR_STAT, 32'h0000_0003);
    wr(`OMCS_ADDR_FEAT, 32'h0000_0000);
    rd(`OMCS_ADDR_STAT, 32'h0000_0001);
    $display("test modes done");
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 8 : (i == 1) ? 9 : (i == 2) ? 4 : 5;
      wr(`OMCS_ADDR_CFG, 32'(m));
      h = 2 + int'($urandom % 7);
      pulse(16, h, t, g);
      chk("ticks", 32'h0000_0010, 32'(t));
      chk("toggles", (m % 2) ? 32'h0 : 32'h8, 32'(g));
    end
    wr(`OMCS_ADDR_CFG, 32'h0000_0008);
    sleep_req <= 1'b1;
    pulse(8, 4, t, g);
    chk("sleep ticks", 32'h0000_0000, 32'(t));
    sleep_req <= 1'b0;
    pulse(8, 4, t, g);
    chk("wake ticks", 32'h0000_0008, 32'(t));
    $display("test external done");
    for (m = 2; m < 4; m++) begin
      wr(`OMCS_ADDR_CFG, 32'(m));
      pulse(OST, 8, t, g);
      rd(`OMCS_ADDR_STAT, 32'({m == 3, 3'b001}));
      pulse(8, 8, t, g);
      chk("xtal ticks", (m == 3) ? 32'h20 : 32'h8, 32'(t));
    end
    $display("test crystal done");
    wr(`OMCS_ADDR_CFG, 32'h0000_0006);
    r = $urandom % 8;
    for (m = 0; m < 8; m++) begin
      h = (m + r) % 8;
      wr(`OMCS_ADDR_CTRL, 32'(h) << 4);
      rd(`OMCS_ADDR_CTRL, 32'(h) << 4);
      rd(`OMCS_ADDR_STAT, 32'({1'b0, h != 0, 2'b11}));
      pulse(40, 100, t, g);
      chk_near("int ticks", int'(64'd8000 * ((h == 0) ? 64'd31250 : (64'd8000000 >> (7 - h)))
               / 64'd125000000), t);
      chk_near("int toggles", t / 2, g);
    end
    $display("test internal done");
    pv = 2'($urandom);
    ext6 <= pv[0];
    wr(`OMCS_ADDR_CFG, 32'h0000_0007);
    wr(`OMCS_ADDR_TRIS, 32'h0000_0000);
    rd(`OMCS_ADDR_PORTA, 32'({pv[0], 6'h00}));
    wr(`OMCS_ADDR_TRIS, 32'h0000_00c0);
    wr(`OMCS_ADDR_PORTA, 32'(pv) << 6);
    chk("in drv", 32'({pv[1], 1'b1}), 32'(in_drv));
    chk("out drv", 32'({pv[0], 1'b1}), 32'(out_drv));
    for (int i = 0; i < 2; i++) begin
      wr(`OMCS_ADDR_CFG, (i == 0) ? 32'h9 : 32'h5);
      chk("io out drv", 32'({pv[0], 1'b1}), 32'(out_drv));
      chk("io in oe", 32'h0000_0000, 32'(in_drv.oe));
    end
    $display("test io done");
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`OMCS_ADDR_CFG, 32'h0000_0007);
    $display("test rereset done");
    finish_test();
  end
endmodule : omcs_top_test

/* File: inc/omcs_defs.svh */
/*
  Constants of the oscillator mode and clock select block: clock rates,
  source rates, register offsets, field positions and reset values.
  Assumes it is included by bare name after the package is compiled.
*/
// Function
// - PLL mode multiplies crystal by four, max 40 MHz
// - PLL enabled only in PLL crystal mode
// - No start-up delay in external clock modes
// - External clock mode drives clock/4 on out pin
// - External clock IO mode: out pin is port A bit 6
// - RC mode drives clock/4 on out pin
// - RC IO mode: out pin is port A bit 6
// - Fast source 8 MHz, postscaled 125 kHz to 4 MHz
// - Fast source on for 125 kHz to 8 MHz selection
// - Slow source nominal 31 kHz from internal block
// - Slow source on for internal clock or features
// - Frequency select picks fast, slow or postscaled source
// - Internal clock-out mode: clock/4 out, in pin IO
// - Internal all-IO mode: both pins are port A IO
// - Eight frequency choices; change acts immediately
`ifndef OMCS_DEFS_SVH
`define OMCS_DEFS_SVH

// ****************************************
// Rates
// ****************************************
`define OMCS_CLK_PERIOD_PS 8000
`define OMCS_CLK_HZ        125000000
`define OMCS_FAST_HZ       8000000
`define OMCS_SLOW_HZ       31250
`define OMCS_PLL_MAX_MHZ   40
`define OMCS_XTAL_MAX_MHZ  10
`define OMCS_PLL_MIN_PS    (1000000 / `OMCS_PLL_MAX_MHZ)
`define OMCS_PLL_MIN_CYC   ((`OMCS_PLL_MIN_PS + `OMCS_CLK_PERIOD_PS - 1) / `OMCS_CLK_PERIOD_PS)
`define OMCS_OST_EDGES     1024

// ****************************************
// Register map
// ****************************************
`define OMCS_ADDR_CFG      8'h00
`define OMCS_ADDR_CTRL     8'h04
`define OMCS_ADDR_STAT     8'h08
`define OMCS_ADDR_FEAT     8'h0C
`define OMCS_ADDR_PORTA    8'h10
`define OMCS_ADDR_TRIS     8'h14
`define OMCS_CFG_RESET     4'h7
`define OMCS_IFS_RESET     3'h0
`define OMCS_IFS_LSB       4
`define OMCS_FEAT_RESET    4'h0
`define OMCS_IO6_BIT       6
`define OMCS_IO7_BIT       7

`endif

/* File: inc/omcs_pkg.sv */
/*
  Types of the oscillator mode and clock select block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package omcs_pkg;

  // ****************************************
  // Oscillator modes
  // ****************************************
  typedef enum logic [3:0] {
    low_power_crystal_mode     = 4'b0000,
    crystal_mode               = 4'b0001,
    high_speed_crystal_mode    = 4'b0010,
    pll_crystal_mode           = 4'b0011,
    resistor_capacitor_mode    = 4'b0100,
    resistor_capacitor_io_mode = 4'b0101,
    internal_clock_out_mode    = 4'b0110,
    internal_all_io_mode       = 4'b0111,
    external_clock_mode        = 4'b1000,
    external_clock_io_mode     = 4'b1001
  } omcs_mode_t;

  // ****************************************
  // Pin drive
  // ****************************************
  typedef struct packed {
    logic o;
    logic oe;
  } omcs_pin_t;

  // ****************************************
  // Source enables
  // ****************************************
  typedef struct packed {
    logic pll;
    logic fast;
    logic slow;
    logic ready;
  } omcs_src_t;

endpackage : omcs_pkg

/* File: rtl/omcs_tick_gen.sv */
/*
  Fractional tick generator: one pulse per period of OUT_HZ, counted
  exactly from CLK_HZ by a modulo accumulator.
  Assumes OUT_HZ is below CLK_HZ and rst_n is synchronous to clk.
*/
`timescale 1ns/1ps
module omcs_tick_gen #(
  parameter int unsigned CLK_HZ = 125000000,
  parameter int unsigned OUT_HZ = 8000000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic en,
  // Output
  output logic      tick
);

  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  logic        tick_r;
  logic [31:0] sum;
  logic        wrap;

  // Exact average rate, jitter of one clk period
  assign sum     = acc_r + OUT_HZ;
  assign wrap    = (sum >= CLK_HZ);
  assign acc_nxt = wrap ? (sum - CLK_HZ) : sum;
  assign tick    = tick_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      acc_r  <= en ? acc_nxt : 32'h0000_0000;
      tick_r <= en & wrap;
    end
  end

endmodule : omcs_tick_gen

/* File: rtl/omcs_top.sv */
/*
  Oscillator mode and clock select block: decodes the oscillator mode,
  runs the PLL, start-up timer and internal sources, gives one system
  clock tick per oscillator period (four in PLL mode) and steers the two oscillator pins.
  Assumes pin inputs are synchronous to clk and an Avalon-MM master.
*/
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "omcs_defs.svh"
module omcs_top #(
  parameter int unsigned OST_EDGES = `OMCS_OST_EDGES,
  parameter int unsigned CLK_HZ    = `OMCS_CLK_HZ,
  parameter int unsigned FAST_HZ   = `OMCS_FAST_HZ,
  parameter int unsigned SLOW_HZ   = `OMCS_SLOW_HZ
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // Avalon-MM slave
  input  wire logic [7:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  // Oscillator pins
  input  wire logic                osc_in_pin_i,
  output omcs_pkg::omcs_pin_t      osc_in_pin_drv,
  input  wire logic                osc_out_pin_i,
  output omcs_pkg::omcs_pin_t      osc_out_pin_drv,
  // Core side
  input  wire logic                sleep_req,
  output logic                     sys_clk_tick,
  output omcs_pkg::omcs_src_t      src_status
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [3:0]  cfg_r;
  logic [2:0]  ifs_r;
  logic [3:0]  feat_r;
  logic [1:0]  io_out_r;
  logic [1:0]  io_oe_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  wire req      = read | write;
  wire wr_take  = write & ack_r;
  wire sel_cfg  = (address == `OMCS_ADDR_CFG);
  wire sel_ctrl = (address == `OMCS_ADDR_CTRL);
  wire sel_stat = (address == `OMCS_ADDR_STAT);
  wire sel_feat = (address == `OMCS_ADDR_FEAT);
  wire sel_pa   = (address == `OMCS_ADDR_PORTA);
  wire sel_tris = (address == `OMCS_ADDR_TRIS);

  // One wait cycle: request seen, answer on the next edge
  assign waitrequest = req & ~ack_r;
  assign readdata    = rdata_r;

  // ****************************************
  // Mode decode
  // ****************************************
  omcs_pkg::omcs_mode_t mode;
  assign mode = omcs_pkg::omcs_mode_t'(cfg_r);

  wire m_lp    = (mode == omcs_pkg::low_power_crystal_mode);
  wire m_xt    = (mode == omcs_pkg::crystal_mode);
  wire m_hs    = (mode == omcs_pkg::high_speed_crystal_mode);
  wire m_pll   = (mode == omcs_pkg::pll_crystal_mode);
  wire m_rc    = (mode == omcs_pkg::resistor_capacitor_mode);
  wire m_resistor_capacitor_io_mode  = (mode == omcs_pkg::resistor_capacitor_io_mode);
  wire m_int1  = (mode == omcs_pkg::internal_clock_out_mode);
  wire m_ec    = (mode == omcs_pkg::external_clock_mode);
  wire m_external_clock_io_mode  = (mode == omcs_pkg::external_clock_io_mode);
  wire is_xtal = m_lp | m_xt | m_hs | m_pll;
  wire is_rc   = m_rc | m_resistor_capacitor_io_mode;
  wire is_ec   = m_ec | m_external_clock_io_mode;
  // Unused codes fall back to internal all-IO: pins stay safe
  wire is_int  = ~is_xtal & ~is_rc & ~is_ec;
  wire clkout  = m_ec | m_rc | m_int1;
  wire io6     = m_external_clock_io_mode | m_resistor_capacitor_io_mode | (is_int & ~m_int1);
  wire io7     = is_int;

  // ****************************************
  // External oscillator edge
  // ****************************************
  logic osc_in_d_r;
  wire  ext_edge = osc_in_pin_i & ~osc_in_d_r;

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      osc_in_d_r <= 1'b0;
    end else begin
      osc_in_d_r <= osc_in_pin_i;
    end
  end

  // ****************************************
  // Times-four PLL
  // ****************************************
  localparam logic [15:0] PLL_MIN = 16'(`OMCS_PLL_MIN_CYC);
  logic [15:0] per_cnt_r;
  logic [15:0] per_r;
  logic [15:0] sub_r;
  logic [1:0]  ph_r;
  logic [15:0] gap_r;

  wire        pll_en  = m_pll;
  wire [15:0] quarter = per_r >> 2;
  // Clamp keeps the multiplied clock at or below its ceiling
  wire [15:0] q_lim   = (quarter < PLL_MIN) ? PLL_MIN : quarter;
  wire        sub_hit = (sub_r == q_lim - 16'h0001) && (ph_r != 2'h3);
  wire        pll_room = (gap_r >= PLL_MIN - 16'h0001);
  wire        pll_tick = pll_en & (ext_edge | sub_hit) & pll_room;

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      per_cnt_r <= 16'h0000;
      per_r     <= 16'hFFFF;
    end else if (!pll_en) begin
      per_cnt_r <= 16'h0000;
      per_r     <= 16'hFFFF;
    end else if (ext_edge) begin
      per_cnt_r <= 16'h0001;
      per_r     <= per_cnt_r;
    end else if (per_cnt_r != 16'hFFFF) begin
      per_cnt_r <= per_cnt_r + 16'h0001;
    end
  end

  // Restarted crystal shortens one period: drop a tick, never crowd
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      gap_r <= 16'hFFFF;
    end else if (pll_tick) begin
      gap_r <= 16'h0000;
    end else if (gap_r != 16'hFFFF) begin
      gap_r <= gap_r + 16'h0001;
    end
  end

  // Four ticks per crystal period, re-aligned on every crystal edge
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sub_r <= 16'h0000;
      ph_r  <= 2'h0;
    end else if (!pll_en || ext_edge) begin
      sub_r <= 16'h0000;
      ph_r  <= 2'h0;
    end else if (sub_hit) begin
      sub_r <= 16'h0000;
      ph_r  <= ph_r + 2'h1;
    end else begin
      sub_r <= sub_r + 16'h0001;
    end
  end

  // ****************************************
  // Internal oscillator block
  // ****************************************
  logic fast_tick;
  logic slow_tick;
  logic [5:0] ps_r;

  wire fast_en = is_int & (ifs_r != 3'h0);
  wire slow_en = is_int | (|feat_r);

  omcs_tick_gen #(
    .CLK_HZ (CLK_HZ),
    .OUT_HZ (FAST_HZ)
  ) u_fast (
    .clk    (clk),
    .rst_n  (rst_n_r),
    .en     (fast_en),
    .tick   (fast_tick)
  );

  omcs_tick_gen #(
    .CLK_HZ (CLK_HZ),
    .OUT_HZ (SLOW_HZ)
  ) u_slow (
    .clk    (clk),
    .rst_n  (rst_n_r),
    .en     (slow_en),
    .tick   (slow_tick)
  );

  // Postscaler: select 1 divides by 64, select 6 by 2
  wire [2:0] ps_sh   = ifs_r - 3'h1;
  wire [5:0] ps_mask = 6'h3F >> ps_sh;
  wire       ps_hit  = fast_tick & (&(ps_r | ~ps_mask));

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ps_r <= 6'h00;
    end else if (fast_tick) begin
      ps_r <= ps_r + 6'h01;
    end
  end

  // Select acts on the very next tick, no re-sync
  wire int_tick = (ifs_r == 3'h0) ? slow_tick :
                  (ifs_r == 3'h7) ? fast_tick : ps_hit;

  // ****************************************
  // Start-up timer
  // ****************************************
  localparam logic [15:0] OST_LAST = 16'(OST_EDGES - 1);
  logic [15:0] ost_r;
  logic        ost_done_r;
  logic        sleep_d_r;

  wire sleep_exit = sleep_d_r & ~sleep_req;

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ost_r      <= 16'h0000;
      ost_done_r <= 1'b0;
      sleep_d_r  <= 1'b0;
    end else begin
      sleep_d_r <= sleep_req;
      if (sleep_exit || !is_xtal) begin
        ost_r      <= 16'h0000;
        ost_done_r <= 1'b0;
      end else if (ext_edge && !ost_done_r) begin
        ost_r      <= ost_r + 16'h0001;
        ost_done_r <= (ost_r == OST_LAST);
      end
    end
  end

  // External and RC clocks need no wait at reset or wake-up
  wire osc_ready = ~is_xtal | ost_done_r;

  // ****************************************
  // System clock tick
  // ****************************************
  wire src_tick = m_pll   ? pll_tick :
                  is_int  ? int_tick : ext_edge;

  assign sys_clk_tick = src_tick & osc_ready & ~sleep_req;

  // ****************************************
  // Clock divided by four
  // ****************************************
  logic [1:0] div_r;
  logic       clkout_r;
  logic       amp_r;

  // Counter bit 1 gives two ticks high, two low
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_r    <= 2'h0;
      clkout_r <= 1'b0;
      amp_r    <= 1'b0;
    end else begin
      if (sys_clk_tick) begin
        div_r <= div_r + 2'h1;
      end
      clkout_r <= div_r[1];
      amp_r    <= ~osc_in_pin_i;
    end
  end

  // ****************************************
  // Pin steering
  // ****************************************
  wire out6_o  = clkout ? clkout_r : (is_xtal ? amp_r : io_out_r[0]);
  wire out6_oe = clkout | is_xtal | (io6 & io_oe_r[0]);

  assign osc_out_pin_drv.o  = out6_o;
  assign osc_out_pin_drv.oe = out6_oe;
  assign osc_in_pin_drv.o   = io_out_r[1];
  assign osc_in_pin_drv.oe  = io7 & io_oe_r[1];

  assign src_status.pll   = pll_en;
  assign src_status.fast  = fast_en;
  assign src_status.slow  = slow_en;
  assign src_status.ready = osc_ready;

  // ****************************************
  // Read mux
  // ****************************************
  wire [1:0] pa_in = {io7 & osc_in_pin_i, io6 & osc_out_pin_i};

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (sel_cfg) begin
      rdata_nxt[3:0] = cfg_r;
    end else if (sel_ctrl) begin
      rdata_nxt[`OMCS_IFS_LSB +: 3] = ifs_r;
    end else if (sel_stat) begin
      rdata_nxt[7:0] = {4'h0, pll_en, fast_en, slow_en, osc_ready};
    end else if (sel_feat) begin
      rdata_nxt[3:0] = feat_r;
    end else if (sel_pa) begin
      rdata_nxt[`OMCS_IO7_BIT:`OMCS_IO6_BIT] = pa_in;
    end else if (sel_tris) begin
      rdata_nxt[`OMCS_IO7_BIT:`OMCS_IO6_BIT] = io_oe_r;
    end
  end

  // ****************************************
  // Bus handshake
  // ****************************************
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= req & ~ack_r;
      rdata_r <= (read & ~ack_r) ? rdata_nxt : rdata_r;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_r  <= `OMCS_CFG_RESET;
      ifs_r  <= `OMCS_IFS_RESET;
      feat_r <= `OMCS_FEAT_RESET;
    end else if (wr_take) begin
      if (sel_cfg) begin
        cfg_r <= writedata[3:0];
      end
      if (sel_ctrl) begin
        ifs_r <= writedata[`OMCS_IFS_LSB +: 3];
      end
      if (sel_feat) begin
        feat_r <= writedata[3:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      io_out_r <= 2'h0;
      io_oe_r  <= 2'h0;
    end else if (wr_take) begin
      if (sel_pa) begin
        io_out_r <= writedata[`OMCS_IO7_BIT:`OMCS_IO6_BIT];
      end
      if (sel_tris) begin
        io_oe_r <= writedata[`OMCS_IO7_BIT:`OMCS_IO6_BIT];
      end
    end
  end

endmodule : omcs_top
